// ---- design/scs_pkg.sv ----
// Shared constants, codes and carrier types of the sync clock selector
package scs_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned MINUTE_S = 60;
    localparam int unsigned MINUTE_CYCLES = MINUTE_S * CLK_HZ;
    localparam int unsigned HOLD_LEARN_MS = 1000;
    localparam int unsigned HOLD_LEARN_CYCLES = HOLD_LEARN_MS * (CLK_HZ / 1000);

    // ****************************************************************
    // Field widths and limits
    // ****************************************************************
    localparam int QL_W = 4;
    localparam int PRIO_W = 4;
    localparam int RESTORE_WAIT_W = 4;
    localparam logic [3:0] RESTORE_WAIT_OFF = 4'h0;
    localparam logic [3:0] RESTORE_WAIT_MAX = 4'hC;

    // ****************************************************************
    // Quality codes, higher value ranks better
    // ****************************************************************
    localparam logic [3:0] NO_QUALITY_CODE = 4'h0;
    localparam logic [3:0] QL_INV = 4'h1;
    localparam logic [3:0] QL_DNU = 4'h2;
    localparam logic [3:0] QL_EEC1 = 4'h3;
    localparam logic [3:0] QL_EEC2 = 4'h4;
    localparam logic [3:0] QL_SSUB = 4'h5;
    localparam logic [3:0] QL_SSUA = 4'h6;
    localparam logic [3:0] QL_PRC = 4'h7;
    localparam logic [3:0] LINK_DOWN_QUALITY_CODE = 4'h8;
    localparam logic [3:0] NO_MESSAGE_QUALITY_CODE = 4'h9;

    // ****************************************************************
    // Modes and selector states
    // ****************************************************************
    typedef enum logic [1:0] {
        MODE_FORCE_FREE = 2'h0,
        MODE_FORCE_HOLD = 2'h1,
        MODE_MANUAL = 2'h2,
        MODE_AUTO = 2'h3
    } scs_mode_t;

    localparam scs_mode_t MODE_RESET = MODE_FORCE_FREE;

    typedef enum logic [1:0] {
        ST_FREE_RUN = 2'h0,
        ST_LOCKED = 2'h1,
        ST_HOLDOVER = 2'h3
    } scs_state_t;

    // ****************************************************************
    // Per-source carriers
    // ****************************************************************
    typedef struct packed {
        logic nominated;
        logic msgEnable;
        logic overrideEn;
        logic [QL_W-1:0] overrideQl;
        logic [PRIO_W-1:0] prio;
        logic [RESTORE_WAIT_W-1:0] restoreWaitMin;
    } scs_src_cfg_t;

    typedef struct packed {
        logic linkUp;
        logic sourceSignalLost;
        logic msgValid;
        logic [QL_W-1:0] rxQl;
    } scs_src_rx_t;

endpackage

// ---- design/scs_sync_clock_selector.sv ----
// Reference clock selector with wait-to-restore and quality message handling
`timescale 1ns/1ps
`default_nettype none

module scs_sync_clock_selector
    import scs_pkg::*;
#(
    parameter int NSRC = 2,
    parameter int SW = 1,
    parameter int unsigned TICK_CYCLES = MINUTE_CYCLES,
    parameter int unsigned LEARN_CYCLES = HOLD_LEARN_CYCLES
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire scs_src_cfg_t [NSRC-1:0] srcCfg,
    input wire scs_src_rx_t [NSRC-1:0] srcRx,
    input wire logic [NSRC-1:0] restoreWaitClear,
    input wire scs_mode_t modeReq,
    input wire logic modeWr,
    input wire logic [SW-1:0] manualSource,
    input wire logic [QL_W-1:0] holdoverQl,
    input wire logic [QL_W-1:0] freeRunQl,
    output var scs_mode_t modeState,
    output var scs_state_t selState,
    output logic [SW-1:0] lockedSource,
    output logic lockLossAlarm,
    output logic invalidParam,
    output logic [QL_W-1:0] txQl,
    output logic [NSRC-1:0][QL_W-1:0] rxQlReport,
    output logic [NSRC-1:0] restoreWaitActive,
    output logic [NSRC-1:0] clkRouteEn,
    output logic holdValid
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [30:0] tickCnt_reg;
    logic minuteTick_reg;
    logic [NSRC-1:0] usable;
    logic [NSRC-1:0] lostPrev_reg;
    logic [NSRC-1:0] recovered;
    logic [NSRC-1:0][QL_W-1:0] effQl;
    logic [NSRC-1:0][RESTORE_WAIT_W-1:0] restoreWaitCnt_reg;
    logic bestOk;
    logic [SW-1:0] bestIdx;
    logic [QL_W-1:0] bestQl;
    logic [PRIO_W-1:0] bestPrio;
    logic manualOk;
    scs_state_t stateNext;
    logic [SW-1:0] srcNext;
    logic [QL_W-1:0] nextLockQl;
    logic [31:0] learnCnt_reg;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // ****************************************************************
    // Mode setting
    // ****************************************************************
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            modeState <= MODE_RESET;
            invalidParam <= 1'b0;
        end
        else if (ce)
        begin
            invalidParam <= 1'b0;
            if (modeWr)
            begin
                if (modeState == MODE_FORCE_FREE && modeReq == MODE_FORCE_HOLD)
                begin
                    invalidParam <= 1'b1;
                end
                else
                begin
                    modeState <= modeReq;
                end
            end
        end
    end

    a_mode_reject: assert property (ce && modeWr && modeState == MODE_FORCE_FREE
        && modeReq == MODE_FORCE_HOLD |=> invalidParam && modeState == MODE_FORCE_FREE)
        else $error("forced holdover request from forced free run not refused");

    // ****************************************************************
    // One-minute tick
    // ****************************************************************
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            tickCnt_reg <= '0;
            minuteTick_reg <= 1'b0;
        end
        else if (ce)
        begin
            if (tickCnt_reg == 31'(TICK_CYCLES - 1))
            begin
                tickCnt_reg <= '0;
                minuteTick_reg <= 1'b1;
            end
            else
            begin
                tickCnt_reg <= tickCnt_reg + 31'h1;
                minuteTick_reg <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Per-source quality, restore wait and received report
    // ****************************************************************
    for (genvar i = 0; i < NSRC; i++)
    begin : g_src
        assign recovered[i] = lostPrev_reg[i] && !srcRx[i].sourceSignalLost;
        assign effQl[i] = srcCfg[i].overrideEn ? srcCfg[i].overrideQl :
            (srcCfg[i].msgEnable && srcRx[i].linkUp && srcRx[i].msgValid) ? srcRx[i].rxQl :
            NO_QUALITY_CODE;
        assign usable[i] = srcCfg[i].nominated && srcRx[i].linkUp
            && !srcRx[i].sourceSignalLost && !restoreWaitActive[i];
        assign restoreWaitActive[i] = restoreWaitCnt_reg[i] != '0;

        always_ff @(posedge clk_sys or posedge rst)
        begin
            if (rst)
            begin
                lostPrev_reg[i] <= 1'b0;
                restoreWaitCnt_reg[i] <= '0;
            end
            else if (ce)
            begin
                lostPrev_reg[i] <= srcRx[i].sourceSignalLost;
                if (recovered[i])
                begin
                    if (srcCfg[i].restoreWaitMin > RESTORE_WAIT_MAX)
                    begin
                        restoreWaitCnt_reg[i] <= RESTORE_WAIT_MAX;
                    end
                    else
                    begin
                        restoreWaitCnt_reg[i] <= srcCfg[i].restoreWaitMin;
                    end
                end
                else if (restoreWaitClear[i])
                begin
                    restoreWaitCnt_reg[i] <= '0;
                end
                else if (minuteTick_reg && restoreWaitCnt_reg[i] != '0)
                begin
                    restoreWaitCnt_reg[i] <= restoreWaitCnt_reg[i] - 4'h1;
                end
            end
        end

        always_ff @(posedge clk_sys or posedge rst)
        begin
            if (rst)
            begin
                rxQlReport[i] <= LINK_DOWN_QUALITY_CODE;
                clkRouteEn[i] <= 1'b0;
            end
            else if (ce)
            begin
                clkRouteEn[i] <= srcCfg[i].nominated;
                if (!srcRx[i].linkUp)
                begin
                    rxQlReport[i] <= LINK_DOWN_QUALITY_CODE;
                end
                else if (srcCfg[i].msgEnable && !srcRx[i].msgValid)
                begin
                    rxQlReport[i] <= NO_MESSAGE_QUALITY_CODE;
                end
                else if (srcCfg[i].msgEnable)
                begin
                    rxQlReport[i] <= srcRx[i].rxQl;
                end
                else
                begin
                    rxQlReport[i] <= NO_QUALITY_CODE;
                end
            end
        end

        sequence s_recover;
            ce && recovered[i] && srcCfg[i].restoreWaitMin != RESTORE_WAIT_OFF;
        endsequence

        a_wait_start: assert property (s_recover |=> restoreWaitActive[i])
            else $error("restore wait did not start on recovery");
        a_wait_clear: assert property (ce && restoreWaitClear[i] && !recovered[i] |=> !restoreWaitActive[i])
            else $error("restore wait not stopped by clear");
        a_wait_block: assert property (restoreWaitActive[i] |-> !usable[i])
            else $error("source usable during restore wait");
        a_rx_link: assert property (ce && !srcRx[i].linkUp |=> rxQlReport[i] == LINK_DOWN_QUALITY_CODE)
            else $error("link down code not reported");
        a_rx_nomsg: assert property (ce && srcRx[i].linkUp && srcCfg[i].msgEnable && !srcRx[i].msgValid
            |=> rxQlReport[i] == NO_MESSAGE_QUALITY_CODE)
            else $error("no message code not reported");
    end

    // ****************************************************************
    // Best source search
    // ****************************************************************
    always_comb
    begin
        bestOk = 1'b0;
        bestIdx = '0;
        bestQl = '0;
        bestPrio = '0;
        for (int i = 0; i < NSRC; i++)
        begin
            if (usable[i] && (!bestOk || effQl[i] > bestQl
                || (effQl[i] == bestQl && srcCfg[i].prio < bestPrio)))
            begin
                bestOk = 1'b1;
                bestIdx = SW'(i);
                bestQl = effQl[i];
                bestPrio = srcCfg[i].prio;
            end
        end
    end

    always_comb
    begin
        manualOk = 1'b0;
        for (int i = 0; i < NSRC; i++)
        begin
            if (manualSource == SW'(i) && usable[i])
            begin
                manualOk = 1'b1;
            end
        end
    end

    // ****************************************************************
    // Selector state
    // ****************************************************************
    always_comb
    begin
        srcNext = lockedSource;
        case (modeState)
            MODE_FORCE_FREE:
            begin
                stateNext = ST_FREE_RUN;
            end
            MODE_FORCE_HOLD:
            begin
                stateNext = holdValid ? ST_HOLDOVER : ST_FREE_RUN;
            end
            MODE_MANUAL:
            begin
                if (manualOk)
                begin
                    stateNext = ST_LOCKED;
                    srcNext = manualSource;
                end
                else
                begin
                    stateNext = holdValid ? ST_HOLDOVER : ST_FREE_RUN;
                end
            end
            default:
            begin
                if (bestOk)
                begin
                    stateNext = ST_LOCKED;
                    srcNext = bestIdx;
                end
                else
                begin
                    stateNext = holdValid ? ST_HOLDOVER : ST_FREE_RUN;
                end
            end
        endcase
    end

    always_comb
    begin
        nextLockQl = NO_QUALITY_CODE;
        for (int i = 0; i < NSRC; i++)
        begin
            if (srcNext == SW'(i))
            begin
                nextLockQl = effQl[i];
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            selState <= ST_FREE_RUN;
            lockedSource <= '0;
            txQl <= NO_QUALITY_CODE;
        end
        else if (ce)
        begin
            selState <= stateNext;
            lockedSource <= srcNext;
            case (stateNext)
                ST_LOCKED:
                begin
                    txQl <= nextLockQl;
                end
                ST_HOLDOVER:
                begin
                    txQl <= holdoverQl;
                end
                default:
                begin
                    txQl <= freeRunQl;
                end
            endcase
        end
    end

    // ****************************************************************
    // Holdover learning and lock loss alarm
    // ****************************************************************
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            learnCnt_reg <= '0;
            holdValid <= 1'b0;
        end
        else if (ce)
        begin
            if (selState == ST_LOCKED && stateNext == ST_LOCKED && srcNext == lockedSource)
            begin
                if (learnCnt_reg >= LEARN_CYCLES - 1)
                begin
                    holdValid <= 1'b1;
                end
                else
                begin
                    learnCnt_reg <= learnCnt_reg + 32'h1;
                end
            end
            else
            begin
                learnCnt_reg <= '0;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            lockLossAlarm <= 1'b0;
        end
        else if (ce)
        begin
            if (selState == ST_LOCKED && stateNext != ST_LOCKED)
            begin
                lockLossAlarm <= 1'b1;
            end
            else if (stateNext == ST_LOCKED)
            begin
                lockLossAlarm <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Checks on the selector
    // ****************************************************************
    a_forced_free: assert property (ce && modeState == MODE_FORCE_FREE |=> selState == ST_FREE_RUN)
        else $error("forced free run left free run state");
    a_forced_hold: assert property (ce && modeState == MODE_FORCE_HOLD && holdValid
        |=> selState == ST_HOLDOVER)
        else $error("forced holdover did not enter holdover");
    a_manual_lock: assert property (ce && modeState == MODE_MANUAL && manualOk
        |=> selState == ST_LOCKED && lockedSource == $past(manualSource))
        else $error("manual mode not locked to manual source");
    a_manual_fail: assert property (ce && modeState == MODE_MANUAL && !manualOk && holdValid
        |=> selState == ST_HOLDOVER)
        else $error("manual source failure did not enter holdover");
    a_free_unlearned: assert property (selState != ST_LOCKED && !holdValid |-> selState == ST_FREE_RUN)
        else $error("holdover shown without learned offset");
    a_lol_raise: assert property (ce && selState == ST_LOCKED && stateNext != ST_LOCKED
        |=> lockLossAlarm && selState != ST_LOCKED)
        else $error("lock loss alarm not raised");
    a_tx_hold: assert property (ce && stateNext == ST_HOLDOVER |=> txQl == $past(holdoverQl))
        else $error("holdover quality not transmitted");
    a_tx_free: assert property (ce && stateNext == ST_FREE_RUN |=> txQl == $past(freeRunQl))
        else $error("free run quality not transmitted");

endmodule
`default_nettype wire

// ---- verif/scs_phy_model.sv ----
// Behavioural port PHYs feeding link, signal-loss and quality message status
`timescale 1ns/1ps
`default_nettype none
module scs_phy_model
    import scs_pkg::*;
#(
    parameter int NSRC = 2
)
(
    input wire logic clk_sys,
    output var scs_src_rx_t [NSRC-1:0] srcRx
);
    logic [NSRC-1:0] linkUp = '0;
    logic [NSRC-1:0] lost = '0;
    logic [NSRC-1:0] valid = '0;
    logic [NSRC-1:0][QL_W-1:0] ql = '0;
    logic junk = 1'b0;

    // Dead link alternates the last message with its inverse, and toggles valid each cycle
    always @(posedge clk_sys)
    begin
        junk <= ~junk;
    end

    always_comb
    begin
        for (int i = 0; i < NSRC; i++)
        begin
            srcRx[i].linkUp = linkUp[i];
            srcRx[i].sourceSignalLost = lost[i];
            srcRx[i].msgValid = linkUp[i] ? valid[i] : junk;
            srcRx[i].rxQl = linkUp[i] ? ql[i] : ql[i] ^ {QL_W{junk}};
        end
    end

    task automatic set_port(input int i, input logic up, input logic ls, input logic v, input logic [QL_W-1:0] q);
        linkUp[i] = up;
        lost[i] = ls;
        valid[i] = v;
        ql[i] = q;
    endtask
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench of the sync clock selector
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import scs_pkg::*;
    localparam int NS = 2;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    scs_src_cfg_t [NS-1:0] srcCfg = '0;
    scs_src_rx_t [NS-1:0] srcRx;
    logic [NS-1:0] restoreWaitClear = '0;
    scs_mode_t modeReq = MODE_AUTO;
    logic modeWr = 1'b0;
    logic [0:0] manualSource = 1'b0;
    logic [3:0] holdoverQl = 4'h5;
    logic [3:0] freeRunQl = 4'h2;
    scs_mode_t modeState;
    scs_state_t selState;
    logic [0:0] lockedSource;
    logic lockLossAlarm;
    logic invalidParam;
    logic holdValid;
    logic [3:0] txQl;
    logic [NS-1:0][3:0] rxQlReport;
    logic [NS-1:0] restoreWaitActive;
    logic [NS-1:0] clkRouteEn;
    int fail_count = 0;
    int num_checks = 0;
    int seed = 32'h6d83;
    int link[NS] = '{0, 0};
    int lost[NS] = '{0, 0};
    int valid[NS] = '{0, 0};
    int ql[NS] = '{0, 0};
    int waitI[NS] = '{0, 0};
    int expMode = 0;
    int expHold = 0;
    int expAlarm = 0;
    int prevSt = 0;
    int n;

    always #25 clk_sys = ~clk_sys;

    scs_sync_clock_selector #(.NSRC(NS), .SW(1), .TICK_CYCLES(20), .LEARN_CYCLES(10)) u_scs_sync_clock_selector (
        .clk_sys(clk_sys), .rst(rst), .ce(ce), .srcCfg(srcCfg), .srcRx(srcRx), .restoreWaitClear(restoreWaitClear),
        .modeReq(modeReq), .modeWr(modeWr), .manualSource(manualSource), .holdoverQl(holdoverQl),
        .freeRunQl(freeRunQl), .modeState(modeState), .selState(selState), .lockedSource(lockedSource),
        .lockLossAlarm(lockLossAlarm), .invalidParam(invalidParam), .txQl(txQl), .rxQlReport(rxQlReport),
        .restoreWaitActive(restoreWaitActive), .clkRouteEn(clkRouteEn), .holdValid(holdValid));

    scs_phy_model #(.NSRC(NS)) phyModel (.clk_sys(clk_sys), .srcRx(srcRx));

    // ****************************************************************
    // Checking helpers
    // ****************************************************************
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic step(input int c);
        repeat (c) @(posedge clk_sys);
        #1;
    endtask

    function automatic int eff_ql(input int i);
        if (srcCfg[i].overrideEn)
            return int'(srcCfg[i].overrideQl);
        if (srcCfg[i].msgEnable && link[i] != 0 && valid[i] != 0)
            return ql[i];
        return 0;
    endfunction

    function automatic bit usable(input int i);
        return srcCfg[i].nominated && link[i] != 0 && lost[i] == 0 && waitI[i] == 0;
    endfunction

    task automatic set_rx(input int i, input int up, input int ls, input int v, input int q);
        link[i] = up;
        lost[i] = ls;
        valid[i] = v;
        ql[i] = q;
        phyModel.set_port(i, 1'(up), 1'(ls), 1'(v), 4'(q));
    endtask

    // Reference selection, state and quality reports
    task automatic verify(input string name);
        int best;
        int st;
        best = -1;
        for (int i = 0; i < NS; i++)
            if (expMode == MODE_AUTO && usable(i) && (best < 0 || eff_ql(i) > eff_ql(best) ||
                (eff_ql(i) == eff_ql(best) && srcCfg[i].prio < srcCfg[best].prio)))
                best = i;
        if (expMode == MODE_MANUAL && usable(int'(manualSource)))
            best = int'(manualSource);
        st = best >= 0 ? 1 : (expMode == MODE_FORCE_FREE || expHold == 0) ? 0 : 3;
        if (st == 1)
            expHold = 1;
        if (st != 1 && prevSt == 1)
            expAlarm = 1;
        if (st == 1)
            expAlarm = 0;
        prevSt = st;
        check(selState, st);
        if (st == 1)
            check(lockedSource, best);
        check(txQl, st == 1 ? eff_ql(best) : st == 3 ? int'(holdoverQl) : int'(freeRunQl));
        check(lockLossAlarm, expAlarm);
        check(holdValid, expHold);
        for (int i = 0; i < NS; i++)
        begin
            check(rxQlReport[i], link[i] == 0 ? 8 : !srcCfg[i].msgEnable ? 0 : valid[i] == 0 ? 9 : ql[i]);
            check(clkRouteEn[i], srcCfg[i].nominated);
            check(restoreWaitActive[i], waitI[i]);
        end
        $display("test %s finished", name);
    endtask

    task automatic write_mode(input scs_mode_t m);
        logic bad;
        bad = expMode == MODE_FORCE_FREE && m == MODE_FORCE_HOLD;
        modeReq = m;
        modeWr = 1'b1;
        step(1);
        modeWr = 1'b0;
        check(invalidParam, bad);
        if (!bad)
            expMode = m;
        step(1);
        check(invalidParam, 0);
        check(modeState, expMode);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial
    begin
        srcCfg[0].nominated = 1'b1;
        srcCfg[1].nominated = 1'b1;
        srcCfg[0].msgEnable = 1'b1;
        srcCfg[1].msgEnable = 1'b1;
        step(3);
        rst = 1'b0;
        step(2);
        verify("reset");
        set_rx(0, 1, 0, 0, 3);
        set_rx(1, 1, 0, 1, 7);
        step(15);
        verify("rx report and forced free run");
        srcCfg[0].msgEnable = 1'b0;
        step(15);
        verify("message disable");
        srcCfg[0].msgEnable = 1'b1;
        write_mode(MODE_FORCE_HOLD);
        set_rx(0, 1, 1, 1, 3);
        set_rx(1, 1, 1, 1, 7);
        write_mode(MODE_AUTO);
        step(15);
        verify("free run without learning");
        set_rx(0, 1, 0, 1, 3);
        set_rx(1, 1, 0, 1, 7);
        step(15);
        verify("first lock");
        for (int k = 0; k < 8; k++)
        begin
            for (int i = 0; i < NS; i++)
            begin
                srcCfg[i].nominated = 1'($random(seed));
                srcCfg[i].msgEnable = 1'($random(seed));
                srcCfg[i].overrideEn = 1'($random(seed));
                srcCfg[i].overrideQl = 4'($random(seed) & 7);
                srcCfg[i].prio = 4'($random(seed) & 3);
                set_rx(i, 1, 0, 1, $random(seed) & 7);
            end
            manualSource = 1'($random(seed));
            step(15);
            verify("random automatic selection");
        end
        srcCfg = '0;
        srcCfg[1].nominated = 1'b1;
        srcCfg[1].msgEnable = 1'b1;
        srcCfg[1].restoreWaitMin = 4'h2;
        set_rx(1, 1, 1, 1, 7);
        step(15);
        verify("holdover on loss");
        set_rx(1, 1, 0, 1, 7);
        waitI[1] = 1;
        step(2);
        verify("restore wait start");
        step(15);
        verify("restore wait running");
        for (n = 17; n < 80 && restoreWaitActive[1] === 1'b1; n++)
            step(1);
        if (n >= 80)
        begin
            fail_count++;
            tally_and_finish();
        end
        check(n >= 20 && n <= 45, 1);
        waitI[1] = 0;
        step(1);
        verify("restore wait end");
        set_rx(1, 1, 1, 1, 7);
        step(3);
        set_rx(1, 1, 0, 1, 7);
        waitI[1] = 1;
        step(3);
        restoreWaitClear = 2'h2;
        step(1);
        restoreWaitClear = '0;
        waitI[1] = 0;
        step(2);
        verify("restore wait clear");
        srcCfg[1].restoreWaitMin = 4'h0;
        set_rx(1, 1, 1, 1, 7);
        step(3);
        set_rx(1, 1, 0, 1, 7);
        step(2);
        verify("restore wait disabled");
        srcCfg[0].nominated = 1'b1;
        srcCfg[0].msgEnable = 1'b1;
        set_rx(0, 1, 0, 1, 7);
        set_rx(1, 1, 0, 1, 3);
        manualSource = 1'b1;
        write_mode(MODE_MANUAL);
        step(15);
        verify("manual lock");
        set_rx(1, 1, 1, 1, 3);
        step(15);
        verify("manual source failure");
        set_rx(1, 1, 0, 1, 3);
        write_mode(MODE_FORCE_HOLD);
        step(15);
        verify("forced holdover");
        write_mode(MODE_FORCE_FREE);
        step(15);
        verify("forced free run");
        tally_and_finish();
    end

    initial
    begin
        #1000000;
        fail_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
